// ### hdl/twi_slave.sv
// Two-wire slave receiver/transmitter state logic with an APB register file
// ========================================
`timescale 1ns/1ps
`default_nettype none

module twi_slave
	import twi_slave_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic deep_sleep,
	input wire logic arb_lost,
	output logic start_go,
	output logic wake,
	output logic irq
);

	slv_regs_s r_ff, nxt_r;

	// ========================================
	// Bus line conditions, from the second synchroniser stage and its one-cycle delayed copy
	logic scl_rise, scl_fall, start_c, stop_c, addressed;
	assign scl_rise = r_ff.scl_s2 & ~r_ff.scl_q;
	assign scl_fall = ~r_ff.scl_s2 & r_ff.scl_q;
	assign start_c = r_ff.scl_s2 & r_ff.scl_q & r_ff.sda_q & ~r_ff.sda_s2;
	assign stop_c = r_ff.scl_s2 & r_ff.scl_q & ~r_ff.sda_q & r_ff.sda_s2;
	assign addressed = (r_ff.fsm == ST_RX) || (r_ff.fsm == ST_RX_ACK) ||
		(r_ff.fsm == ST_TX) || (r_ff.fsm == ST_TX_ACK);

	// APB decode; zero wait states, reads captured in the setup cycle
	logic acc, wr, setup, mapped, flag_clr, addr_match;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign setup = psel & ~penable;
	assign mapped = (paddr == OFS_CONTROL) || (paddr == OFS_STATUS) ||
		(paddr == OFS_DATA) || (paddr == OFS_OWN_ADDR) ||
		(paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_MASK);
	assign flag_clr = wr && (paddr == OFS_CONTROL) && pwdata[CTL_FLAG] && r_ff.flag;
	// Own address, or general call when bit zero allows it
	assign addr_match = r_ff.ack_en && ((r_ff.shreg[7:1] == r_ff.own_addr[7:1]) ||
		((r_ff.shreg[7:1] == 7'h00) && r_ff.own_addr[0]));

	// ========================================
	// Next state of everything
	always_comb begin
		logic [EV_W-1:0] ev;
		logic [7:0] st_rd;
		ev = '0;
		st_rd = 8'h00;
		nxt_r = r_ff;
		if (ce) begin
			// Two-stage synchronisers on both bus lines
			nxt_r.scl_s1 = scl_i;
			nxt_r.scl_s2 = r_ff.scl_s1;
			nxt_r.sda_s1 = sda_i;
			nxt_r.sda_s2 = r_ff.sda_s1;
			nxt_r.scl_q = r_ff.scl_s2;
			nxt_r.sda_q = r_ff.sda_s2;
			nxt_r.start_go = 1'b0;
			if (start_c) begin
				nxt_r.busy = 1'b1;
			end else if (stop_c) begin
				nxt_r.busy = 1'b0;
			end
			// Software register writes
			if (wr) begin
				unique case (paddr)
					OFS_CONTROL: begin
						nxt_r.ack_en = pwdata[CTL_ACK_EN];
						nxt_r.sta_req = pwdata[CTL_START];
						nxt_r.sto_req = pwdata[CTL_STOP];
						nxt_r.en = pwdata[CTL_ENABLE];
						nxt_r.ien = pwdata[CTL_IEN];
					end
					OFS_STATUS: nxt_r.presc = pwdata[1:0];
					OFS_DATA: begin
						// Writing while the bus owns the byte is a collision
						if (r_ff.flag) begin
							nxt_r.data = pwdata[7:0];
							nxt_r.wcol = 1'b0;
						end else begin
							nxt_r.wcol = 1'b1;
						end
					end
					OFS_OWN_ADDR: nxt_r.own_addr = pwdata[7:0];
					OFS_IRQ_MASK: nxt_r.irq_mask = pwdata[EV_W-1:0];
					default: ;
				endcase
			end
			// Flag clear releases the held bus and picks the next step
			if (flag_clr) begin
				nxt_r.flag = 1'b0;
				nxt_r.stretch = 1'b0;
				nxt_r.wake = 1'b0;
				// A STOP report leaves the engine idle rather than held, so match it by code
				if (r_ff.fsm == ST_HOLD || r_ff.code == SC_STOP_RS) begin
					unique case (r_ff.code)
						SC_SR_DATA_NACK, SC_GC_DATA_NACK, SC_STOP_RS,
						SC_ST_DATA_NACK, SC_ST_LAST_ACK: begin
							nxt_r.fsm = (r_ff.fsm == ST_HOLD) ? ST_IDLE : r_ff.fsm;
							nxt_r.start_pend = pwdata[CTL_START];
						end
						SC_ST_ADDR, SC_ST_ADDR_ARB, SC_ST_DATA_ACK: begin
							nxt_r.fsm = ST_TX;
							nxt_r.bit_cnt = 4'h0;
							nxt_r.shreg = nxt_r.data;
							nxt_r.sda_lo = ~nxt_r.data[7];
							nxt_r.tx_last = ~pwdata[CTL_ACK_EN];
						end
						default: begin
							nxt_r.fsm = ST_RX;
							nxt_r.bit_cnt = 4'h0;
						end
					endcase
				end
			end
			// Slave protocol engine
			if (!r_ff.en) begin
				nxt_r.fsm = ST_IDLE;
				nxt_r.sda_lo = 1'b0;
			end else if (start_c || stop_c) begin
				if (addressed) begin
					nxt_r.flag = 1'b1;
					nxt_r.code = SC_STOP_RS;
					nxt_r.stretch = start_c;
					ev[EV_STOP] = 1'b1;
					ev[EV_FLAG] = r_ff.ien;
				end
				nxt_r.fsm = start_c ? ST_ADDR : ST_IDLE;
				nxt_r.bit_cnt = 4'h0;
				nxt_r.sda_lo = 1'b0;
			end else begin
				unique case (r_ff.fsm)
					ST_IDLE, ST_HOLD: ;
					ST_ADDR: begin
						if (scl_rise) begin
							nxt_r.shreg = {r_ff.shreg[6:0], r_ff.sda_s2};
							nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
						end else if (scl_fall && r_ff.bit_cnt == BITS_PER_BYTE) begin
							if (addr_match) begin
								nxt_r.fsm = ST_ADDR_ACK;
								nxt_r.sda_lo = 1'b1;
								nxt_r.dir_read = r_ff.shreg[0];
								nxt_r.is_gc = (r_ff.shreg[7:1] == 7'h00);
								nxt_r.arb_q = arb_lost;
							end else begin
								nxt_r.fsm = ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						if (scl_fall) begin
							nxt_r.sda_lo = 1'b0;
							nxt_r.flag = 1'b1;
							nxt_r.stretch = 1'b1;
							nxt_r.fsm = ST_HOLD;
							ev[EV_FLAG] = r_ff.ien;
							if (r_ff.dir_read) begin
								nxt_r.code = r_ff.arb_q ? SC_ST_ADDR_ARB : SC_ST_ADDR;
							end else if (r_ff.is_gc) begin
								nxt_r.code = r_ff.arb_q ? SC_GC_ADDR_ARB : SC_GC_ADDR;
							end else begin
								nxt_r.code = r_ff.arb_q ? SC_SR_ADDR_ARB : SC_SR_ADDR;
							end
							// Asleep the byte register is left alone
							if (deep_sleep) begin
								nxt_r.wake = 1'b1;
								ev[EV_WAKE] = 1'b1;
							end else begin
								nxt_r.data = r_ff.shreg;
							end
						end
					end
					ST_RX: begin
						if (scl_rise) begin
							nxt_r.shreg = {r_ff.shreg[6:0], r_ff.sda_s2};
							nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
						end else if (scl_fall && r_ff.bit_cnt == BITS_PER_BYTE) begin
							nxt_r.ack_bit = r_ff.ack_en;
							nxt_r.sda_lo = r_ff.ack_en;
							nxt_r.fsm = ST_RX_ACK;
						end
					end
					ST_RX_ACK: begin
						if (scl_fall) begin
							nxt_r.sda_lo = 1'b0;
							nxt_r.data = r_ff.shreg;
							nxt_r.flag = 1'b1;
							nxt_r.stretch = 1'b1;
							nxt_r.fsm = ST_HOLD;
							ev[EV_FLAG] = r_ff.ien;
							if (r_ff.is_gc) begin
								nxt_r.code = r_ff.ack_bit ? SC_GC_DATA_ACK : SC_GC_DATA_NACK;
							end else begin
								nxt_r.code = r_ff.ack_bit ? SC_SR_DATA_ACK : SC_SR_DATA_NACK;
							end
						end
					end
					ST_TX: begin
						// Bits change only while the clock is low
						if (scl_fall) begin
							if (r_ff.bit_cnt == LAST_TX_FALL) begin
								nxt_r.sda_lo = 1'b0;
								nxt_r.fsm = ST_TX_ACK;
							end else begin
								nxt_r.shreg = {r_ff.shreg[6:0], 1'b1};
								nxt_r.sda_lo = ~r_ff.shreg[6];
								nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
							end
						end
					end
					ST_TX_ACK: begin
						if (scl_rise) begin
							nxt_r.ack_bit = ~r_ff.sda_s2;
						end else if (scl_fall) begin
							nxt_r.flag = 1'b1;
							nxt_r.stretch = 1'b1;
							nxt_r.fsm = ST_HOLD;
							ev[EV_FLAG] = r_ff.ien;
							if (!r_ff.ack_bit) begin
								nxt_r.code = SC_ST_DATA_NACK;
							end else if (r_ff.tx_last) begin
								nxt_r.code = SC_ST_LAST_ACK;
							end else begin
								nxt_r.code = SC_ST_DATA_ACK;
							end
						end
					end
				endcase
			end
			// Deferred START handed to the master engine once the bus is free
			if (r_ff.start_pend && !r_ff.busy && r_ff.en) begin
				nxt_r.start_go = 1'b1;
				nxt_r.start_pend = 1'b0;
			end
			// Read data captured in setup; status shows no-info while flag low
			st_rd = r_ff.flag ? r_ff.code : SC_NO_INFO;
			if (setup) begin
				unique case (paddr)
					OFS_CONTROL: nxt_r.prdata = {24'h000000, r_ff.flag, r_ff.ack_en,
						r_ff.sta_req, r_ff.sto_req, r_ff.wcol, r_ff.en, 1'b0, r_ff.ien};
					OFS_STATUS: nxt_r.prdata = {24'h000000, st_rd[7:3], 1'b0, r_ff.presc};
					OFS_DATA: nxt_r.prdata = {24'h000000, r_ff.data};
					OFS_OWN_ADDR: nxt_r.prdata = {24'h000000, r_ff.own_addr};
					OFS_IRQ_STATUS: nxt_r.prdata = {29'h00000000, r_ff.irq_sts};
					OFS_IRQ_MASK: nxt_r.prdata = {29'h00000000, r_ff.irq_mask};
					default: nxt_r.prdata = 32'h00000000;
				endcase
			end
			// Read clears sticky events; a new event in that cycle still lands
			if (acc && !pwrite && paddr == OFS_IRQ_STATUS) begin
				nxt_r.irq_sts = '0;
			end
			nxt_r.irq_sts = nxt_r.irq_sts | ev;
		end
	end

	// ========================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '0;
			// Line samples start at the idle high level, so no false edge follows reset
			r_ff.scl_s1 <= 1'b1;
			r_ff.scl_s2 <= 1'b1;
			r_ff.scl_q <= 1'b1;
			r_ff.sda_s1 <= 1'b1;
			r_ff.sda_s2 <= 1'b1;
			r_ff.sda_q <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Open-drain pins only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n = ~(r_ff.flag & r_ff.stretch);
	assign sda_oe_n = ~r_ff.sda_lo;
	assign prdata = r_ff.prdata;
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	assign start_go = r_ff.start_go;
	assign wake = r_ff.wake;
	assign irq = |(r_ff.irq_sts & r_ff.irq_mask);

	// ========================================
	// Assertions
	sequence s_addr_end;
		ce && r_ff.en && !start_c && !stop_c && r_ff.fsm == ST_ADDR && scl_fall &&
			r_ff.bit_cnt == BITS_PER_BYTE;
	endsequence

	sequence s_hold_clear(logic [7:0] c);
		ce && flag_clr && r_ff.fsm == ST_HOLD && r_ff.code == c;
	endsequence

	property p_stretch;
		@(posedge pclk) disable iff (!presetn)
		$rose(r_ff.flag) && r_ff.stretch |-> !scl_oe_n [*2] or ##1 !r_ff.flag;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock not held low with flag");

	property p_nack_idle;
		@(posedge pclk) disable iff (!presetn)
		s_hold_clear(SC_GC_DATA_NACK) |=> r_ff.fsm == ST_IDLE && !r_ff.flag;
	endproperty
	a_nack_idle: assert property (p_nack_idle) else $error("no return to idle after nack");

	property p_stop_status;
		@(posedge pclk) disable iff (!presetn)
		ce && r_ff.en && stop_c && addressed |=> r_ff.flag && r_ff.code == SC_STOP_RS &&
			r_ff.fsm == ST_IDLE;
	endproperty
	a_stop_status: assert property (p_stop_status) else $error("stop not reported");

	property p_start_go;
		@(posedge pclk) disable iff (!presetn)
		ce && flag_clr && r_ff.code == SC_STOP_RS && pwdata[CTL_START] ##1
			(ce && r_ff.en && !r_ff.busy) |=> start_go;
	endproperty
	a_start_go: assert property (p_start_go) else $error("pending start not issued");

	property p_no_ack_disabled;
		@(posedge pclk) disable iff (!presetn)
		s_addr_end and !r_ff.ack_en |=> r_ff.fsm == ST_IDLE && sda_oe_n;
	endproperty
	a_no_ack_disabled: assert property (p_no_ack_disabled) else $error("acked while disabled");

	property p_read_to_tx;
		@(posedge pclk) disable iff (!presetn)
		s_addr_end and addr_match and r_ff.shreg[0] |=> !sda_oe_n ##0
			(r_ff.fsm == ST_ADDR_ACK && r_ff.dir_read);
	endproperty
	a_read_to_tx: assert property (p_read_to_tx) else $error("read address not acked");

	property p_last_ack;
		@(posedge pclk) disable iff (!presetn)
		ce && r_ff.en && !start_c && !stop_c && r_ff.fsm == ST_TX_ACK && scl_fall &&
			r_ff.ack_bit && r_ff.tx_last |=> r_ff.code == SC_ST_LAST_ACK && r_ff.flag;
	endproperty
	a_last_ack: assert property (p_last_ack) else $error("last-byte ack state missed");

	property p_idle_released;
		@(posedge pclk) disable iff (!presetn)
		s_hold_clear(SC_ST_LAST_ACK) |=> sda_oe_n && r_ff.fsm == ST_IDLE;
	endproperty
	a_idle_released: assert property (p_idle_released) else $error("data line not released");

	property p_wake_hold;
		@(posedge pclk) disable iff (!presetn)
		$rose(r_ff.wake) |-> !scl_oe_n && r_ff.flag;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake without clock hold");

endmodule

`default_nettype wire

// ### hdl/twi_slave_pkg.sv
// Shared constants, status codes and state types of the two-wire slave block
package twi_slave_pkg;

	// ========================================
	// Register byte addresses on the APB
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_OWN_ADDR = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	// ========================================
	// Bus control field positions
	localparam int CTL_FLAG = 7;
	localparam int CTL_ACK_EN = 6;
	localparam int CTL_START = 5;
	localparam int CTL_STOP = 4;
	localparam int CTL_WCOL = 3;
	localparam int CTL_ENABLE = 2;
	localparam int CTL_IEN = 0;

	// Event bits of the interrupt status and mask registers
	localparam int EV_FLAG = 0;
	localparam int EV_STOP = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_W = 3;

	// ========================================
	// Slave status codes, prescaler bits zero
	localparam logic [7:0] SC_SR_ADDR = 8'h60;
	localparam logic [7:0] SC_SR_ADDR_ARB = 8'h68;
	localparam logic [7:0] SC_GC_ADDR = 8'h70;
	localparam logic [7:0] SC_GC_ADDR_ARB = 8'h78;
	localparam logic [7:0] SC_SR_DATA_ACK = 8'h80;
	localparam logic [7:0] SC_SR_DATA_NACK = 8'h88;
	localparam logic [7:0] SC_GC_DATA_ACK = 8'h90;
	localparam logic [7:0] SC_GC_DATA_NACK = 8'h98;
	localparam logic [7:0] SC_STOP_RS = 8'hA0;
	localparam logic [7:0] SC_ST_ADDR = 8'hA8;
	localparam logic [7:0] SC_ST_ADDR_ARB = 8'hB0;
	localparam logic [7:0] SC_ST_DATA_ACK = 8'hB8;
	localparam logic [7:0] SC_ST_DATA_NACK = 8'hC0;
	localparam logic [7:0] SC_ST_LAST_ACK = 8'hC8;
	localparam logic [7:0] SC_NO_INFO = 8'hF8;

	// Reset values and bit counts
	localparam logic [7:0] RST_OWN_ADDR = 8'h00;
	localparam logic [7:0] RST_CODE = SC_NO_INFO;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_FALL = 4'h7;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_HOLD
	} slv_state_e;

	typedef struct packed {
		slv_state_e fsm;
		logic scl_s1, scl_s2, sda_s1, sda_s2, scl_q, sda_q;
		logic busy;
		logic [3:0] bit_cnt;
		logic [7:0] shreg;
		logic dir_read, is_gc, arb_q, tx_last, ack_bit, sda_lo;
		logic flag, stretch, ack_en, sta_req, sto_req, wcol, en, ien;
		logic [7:0] code;
		logic [1:0] presc;
		logic [7:0] own_addr;
		logic [7:0] data;
		logic start_pend, start_go, wake;
		logic [EV_W-1:0] irq_sts;
		logic [EV_W-1:0] irq_mask;
		logic [31:0] prdata;
	} slv_regs_s;

endpackage

// ### tb/i2c_master_model.sv
// Behavioural two-wire bus master that drives the slave's far side
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
	input wire logic scl,
	input wire logic sda,
	output logic scl_lo,
	output logic sda_lo
);
	// ========================================
	// Open-drain lines, released means pulled up
	initial begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end

	// Release SCL, wait while the slave stretches it; the bench watchdog ends a hang
	task automatic clk_hi();
		scl_lo = 1'b0;
		while (scl !== 1'b1) begin
			#8;
		end
		#20;
	endtask

	// One bit slot of 80 ns, sampled mid high phase
	task automatic bit_slot(input logic b, output logic s);
		#10;
		sda_lo = !b;
		#30;
		clk_hi();
		s = sda;
		#20;
		scl_lo = 1'b1;
	endtask

	// START from an idle bus, offset keeps edges off pclk
	task automatic gen_start();
		#1;
		sda_lo = 1'b1;
		#40;
		scl_lo = 1'b1;
	endtask

	task automatic gen_stop();
		#11;
		sda_lo = 1'b1;
		#30;
		clk_hi();
		#20;
		sda_lo = 1'b0;
		#40;
	endtask

	// Byte out MSB first, then the slave's answer
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		#1;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(b[i], s);
		end
		bit_slot(1'b1, ack);
	endtask

	// Byte in with SDA released, then our own answer
	task automatic rd_byte(input logic a, output logic [7:0] b);
		logic s;
		#1;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, b[i]);
		end
		bit_slot(a, s);
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the two-wire slave block
`timescale 1ns/1ps
`default_nettype none

module tb;
	import twi_slave_pkg::*;
	localparam logic [31:0] ctl_run = 32'h45;
	localparam logic [31:0] ctl_clr = 32'hC5;
	localparam logic [31:0] ctl_last = 32'h85;
	localparam logic [31:0] ctl_sta = 32'hE5;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic deep_sleep = 1'b0;
	logic arb_lost = 1'b0;
	logic ce = 1'b1;
	logic [31:0] prdata, rd;
	logic pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n;
	logic start_go, wake, irq, m_scl_lo, m_sda_lo, scl_w, sda_w, ack, e;
	logic [7:0] by;
	int err_count = 0;
	int checked = 0;
	int go_cnt = 0;
	int g0;

	// ========================================
	// Clock, wired-AND bus lines, start request counter
	always #4 pclk = !pclk;
	assign scl_w = !m_scl_lo && (scl_oe_n || scl_o);
	assign sda_w = !m_sda_lo && (sda_oe_n || sda_o);
	always @(posedge pclk) if (start_go === 1'b1) go_cnt <= go_cnt + 1;

	twi_slave twi_slave_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .deep_sleep(deep_sleep), .arb_lost(arb_lost),
		.start_go(start_go), .wake(wake), .irq(irq));
	i2c_master_model i2c_master_model_i (.scl(scl_w), .sda(sda_w), .scl_lo(m_scl_lo),
		.sda_lo(m_sda_lo));

	// ========================================
	// Compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
		checked++;
		if (got !== x) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, x);
		end
	endtask
	task automatic cb(input logic v, input logic x, input string m);
		chk({31'h0, v}, {31'h0, x}, m);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// APB cycle: setup, then access held until pready at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		r = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, e);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x, input string m);
		apb(1'b0, a, 32'h0, rd, e);
		chk(rd, x, m);
	endtask

	// ========================================
	// Flag polling and per-byte outcome
	task automatic wait_flag();
		int n;
		n = 0;
		rd = 32'h0;
		while (rd[CTL_FLAG] !== 1'b1 && n < 300) begin
			apb(1'b0, OFS_CONTROL, 32'h0, rd, e);
			n++;
		end
		cb(rd[CTL_FLAG], 1'b1, "flag");
		@(negedge pclk);
	endtask
	// Code zero means no flag may follow
	task automatic outcome(input logic [7:0] code);
		if (code !== 8'h00) begin
			wait_flag();
			cb(scl_oe_n, 1'b0, "scl held");
			apb(1'b0, OFS_STATUS, 32'h0, rd, e);
			chk(rd & 32'hF8, {24'h0, code}, "status");
		end else begin
			repeat (20) @(posedge pclk);
			apb(1'b0, OFS_CONTROL, 32'h0, rd, e);
			cb(rd[CTL_FLAG], 1'b0, "no flag");
		end
	endtask
	task automatic wbyte(input logic [7:0] b, input logic xa, input logic [7:0] code);
		i2c_master_model_i.wr_byte(b, ack);
		cb(ack, xa, "ack");
		outcome(code);
	endtask
	task automatic addr(input logic [7:0] b, input logic xa, input logic [7:0] code);
		i2c_master_model_i.gen_start();
		wbyte(b, xa, code);
	endtask
	task automatic rbyte(input logic a, input logic [7:0] xb, input logic [7:0] code);
		i2c_master_model_i.rd_byte(a, by);
		chk({24'h0, by}, {24'h0, xb}, "tx byte");
		outcome(code);
	endtask
	task automatic mstop();
		i2c_master_model_i.gen_stop();
	endtask

	// Hang guard, far above the expected run time
	initial begin
		#400000;
		err_count++;
		complete_run();
	end

	// ========================================
	// Test sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rc(OFS_CONTROL, 32'h0, "ctl rst");
		rc(OFS_STATUS, {24'h0, RST_CODE}, "sts rst");
		rc(OFS_OWN_ADDR, {24'h0, RST_OWN_ADDR}, "own rst");
		rc(OFS_IRQ_MASK, 32'h0, "mask rst");
		apb(1'b0, 8'h40, 32'h0, rd, e);
		chk({rd[30:0], e}, 32'h1, "unmapped");
		wr(OFS_OWN_ADDR, 32'h53);
		wr(OFS_CONTROL, ctl_run);
		wr(OFS_STATUS, 32'h3);
		wr(OFS_IRQ_MASK, 32'h7);
		rc(OFS_IRQ_MASK, 32'h7, "mask rw");
		ce <= 1'b0;
		wr(OFS_IRQ_MASK, 32'h0);
		ce <= 1'b1;
		rc(OFS_IRQ_MASK, 32'h7, "ce frozen");
		wr(OFS_DATA, 32'h77);
		rc(OFS_CONTROL, ctl_run | 32'h8, "wcol");
		$display("test regs finished");
		// Own address receive, then a refused byte
		addr(8'h52, 1'b0, SC_SR_ADDR);
		wr(OFS_CONTROL, ctl_clr);
		wbyte(8'hA5, 1'b0, SC_SR_DATA_ACK);
		rc(OFS_DATA, 32'hA5, "rx data");
		wr(OFS_CONTROL, ctl_last);
		wbyte(8'h5A, 1'b1, SC_SR_DATA_NACK);
		wr(OFS_CONTROL, ctl_last);
		mstop();
		$display("test receive finished");
		// General call: ack follows ack_enable at each clear until a refused byte, then the slave drops out
		wr(OFS_CONTROL, ctl_run);
		addr(8'h00, 1'b0, SC_GC_ADDR);
		wr(OFS_CONTROL, ctl_clr);
		wbyte(8'h11, 1'b0, SC_GC_DATA_ACK);
		wr(OFS_CONTROL, ctl_clr);
		wbyte(8'h22, 1'b0, SC_GC_DATA_ACK);
		rc(OFS_DATA, 32'h22, "gc data");
		wr(OFS_CONTROL, ctl_last);
		wbyte(8'h33, 1'b1, SC_GC_DATA_NACK);
		wr(OFS_CONTROL, ctl_clr);
		wbyte(8'h44, 1'b1, 8'h00);
		mstop();
		$display("test general call finished");
		// STOP while addressed, then clear with a start request
		addr(8'h52, 1'b0, SC_SR_ADDR);
		wr(OFS_CONTROL, ctl_clr);
		mstop();
		wait_flag();
		cb(scl_oe_n, 1'b1, "stop no stretch");
		apb(1'b0, OFS_STATUS, 32'h0, rd, e);
		chk(rd & 32'hF8, {24'h0, SC_STOP_RS}, "stop sts");
		rc(OFS_IRQ_STATUS, 32'h3, "irq sts");
		g0 = go_cnt;
		wr(OFS_CONTROL, ctl_sta);
		for (int n = 0; n < 50 && go_cnt == g0; n++) @(posedge pclk);
		chk(go_cnt - g0, 32'h1, "start go");
		wr(OFS_CONTROL, ctl_run);
		$display("test stop finished");
		// Transmit, last byte acked, then master reads ones
		addr(8'h53, 1'b0, SC_ST_ADDR);
		wr(OFS_DATA, 32'h3C);
		wr(OFS_CONTROL, ctl_clr);
		rbyte(1'b0, 8'h3C, SC_ST_DATA_ACK);
		wr(OFS_DATA, 32'hC3);
		wr(OFS_CONTROL, ctl_last);
		rbyte(1'b0, 8'hC3, SC_ST_LAST_ACK);
		wr(OFS_CONTROL, ctl_clr);
		rbyte(1'b0, 8'hFF, 8'h00);
		mstop();
		// Lost arbitration, last byte refused by the master
		@(posedge pclk);
		arb_lost <= 1'b1;
		addr(8'h53, 1'b0, SC_ST_ADDR_ARB);
		arb_lost <= 1'b0;
		wr(OFS_DATA, 32'h96);
		wr(OFS_CONTROL, ctl_last);
		rbyte(1'b1, 8'h96, SC_ST_DATA_NACK);
		wr(OFS_CONTROL, ctl_clr);
		mstop();
		$display("test transmit finished");
		// Isolation by ack_enable and general call disable
		wr(OFS_CONTROL, 32'h05);
		addr(8'h52, 1'b1, 8'h00);
		mstop();
		wr(OFS_OWN_ADDR, 32'h52);
		wr(OFS_CONTROL, ctl_run);
		addr(8'h00, 1'b1, 8'h00);
		mstop();
		// Deep sleep match with masked then unmasked interrupt
		apb(1'b0, OFS_IRQ_STATUS, 32'h0, rd, e);
		wr(OFS_IRQ_MASK, 32'h0);
		deep_sleep <= 1'b1;
		addr(8'h52, 1'b0, SC_SR_ADDR);
		cb(wake, 1'b1, "wake");
		cb(irq, 1'b0, "irq masked");
		wr(OFS_IRQ_MASK, 32'h7);
		@(negedge pclk);
		cb(irq, 1'b1, "irq on");
		rc(OFS_IRQ_STATUS, 32'h5, "irq wake");
		@(negedge pclk);
		cb(irq, 1'b0, "irq clr");
		cb(scl_oe_n, 1'b0, "wake held");
		rc(OFS_DATA, 32'h96, "wake data");
		wr(OFS_CONTROL, ctl_clr);
		deep_sleep <= 1'b0;
		@(negedge pclk);
		cb(wake, 1'b0, "wake end");
		mstop();
		wait_flag();
		wr(OFS_CONTROL, ctl_clr);
		chk(go_cnt, 32'h1, "go total");
		$display("test sleep finished");
		complete_run();
	end
endmodule
`default_nettype wire
